// [verilog/irv_defines.vh]
// constants for the interrupt and reset vectoring block
// assumes a 250 MHz cpu clock and byte-wide register data
`ifndef IRV_DEFINES_VH
`define IRV_DEFINES_VH
// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define IRV_ADDR_EXT_CTRL 8'h0C
`define IRV_ADDR_MASK 8'h10
`define IRV_ADDR_STATUS 8'h14
`define IRV_ADDR_VECTOR 8'h18
`define IRV_EXT_CTRL_RESET 8'h00
`define IRV_BIT_EN_A 0
`define IRV_BIT_LAT_A 1
`define IRV_BIT_EDGE_A 2
`define IRV_BIT_EN_B 3
`define IRV_BIT_LAT_B 4
`define IRV_BIT_EDGE_B 5
// ----------------------------------------------------------------------
// vectors
// ----------------------------------------------------------------------
`define IRV_VEC_RESET 16'hFFFE
`define IRV_VEC_TRAP 16'hFFFC
`define IRV_VEC_DDC_CI_A 16'hFFF8
`define IRV_VEC_DDC2B_A 16'hFFF6
`define IRV_VEC_DDC_CI_B 16'hFFF4
`define IRV_VEC_DDC2B_B 16'hFFF2
`define IRV_VEC_IFR 16'hFFEE
`define IRV_VEC_EXT_A 16'hFFEC
`define IRV_VEC_EXT_B 16'hFFEA
`define IRV_VEC_I2C 16'hFFE8
`define IRV_VEC_TIM_B 16'hFFE4
`define IRV_VEC_TIM_A 16'hFFE2
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define IRV_CLK_MHZ 250
`define IRV_STARTUP_CYCLES 4096
`define IRV_WDG_PULSE_NS 500
`define IRV_WDG_PULSE_CYCLES ((`IRV_WDG_PULSE_NS * `IRV_CLK_MHZ) / 1000)
`define IRV_EXT_RST_MIN_US 1
`define IRV_EXT_RST_MIN_CYCLES (`IRV_EXT_RST_MIN_US * `IRV_CLK_MHZ)
`endif

// [verilog/irv_top.v]
// interrupt ranking, context save/restore sequencing and reset vectoring
// assumes the cpu core presents one-cycle strobes and honours take/ack
`timescale 1ns/100ps
`include "irv_defines.vh"

// Summary of operation
// - any reset fetches the start address from the top vector pair
// - after oscillator start hold execution a fixed count of cpu cycles
// - a watchdog reset drives the reset pin low for about 500 ns
// - the reset pin stays driven low while low voltage reset is present
// - an illegal opcode from the core causes a reset
// - service entry pushes pc, x, a, condition codes and sets the mask
// - return restores the stacked registers, mask taken from the stack copy
// - peripheral request taken only when flag, enable set and mask clear
// - the software trap is always serviced regardless of the mask
// - with the mask set only the trap is accepted
// - service of a maskable request begins only at the end of the current instruction
// - the trap or any request not blocked by the mask wakes the core out of wait
// - clear sequence on a peripheral latch discards its pending request
// - edge select bits pick falling (0) or rising (1) per input
// - hardware sets the edge latch on the selected edge, software clears
// - per-input enable bits reset to disabled
// - the two top bits of the control register read zero
// - trap, input a and input b each own a vector
// - fixed peripheral vectors, separate vector for each of a channel's two events
// - fixed priority: reset, trap, then descending vector address
module irv_top #(
  parameter STARTUP_CYCLES = `IRV_STARTUP_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [0:0] wb_sel_i,
  input wire [7:0] wb_dat_i,
  output reg [7:0] wb_dat_o,
  output reg wb_ack_o,
  // reset sources and pin
  input wire osc_ready_i,
  input wire wdg_reset_i,
  input wire lvd_reset_i,
  input wire reset_pin_n_i,
  output wire reset_pin_o,
  output wire reset_pin_oe_n_o,
  output reg cpu_reset_o,
  // external interrupt pins
  input wire ext_irq_pin_a_i,
  input wire ext_irq_pin_b_i,
  // peripheral flags: 0 ddc_ci_a 1 ddc2b_a 2 ddc_ci_b 3 ddc2b_b 4 ifr
  // 5 i2c 6 tim_b 7 tim_a
  input wire [7:0] periph_flag_i,
  input wire [7:0] periph_clear_i,
  // cpu core side
  input wire illegal_opcode_i,
  input wire trap_exec_i,
  input wire instr_end_i,
  input wire wait_mode_i,
  input wire interrupt_return_instr_exec_i,
  input wire [7:0] stacked_cc_i,
  input wire [7:0] cc_i,
  input wire [15:0] pc_i,
  input wire [7:0] x_i,
  input wire [7:0] a_i,
  input wire push_ack_i,
  output reg service_o,
  output reg [15:0] vector_o,
  output reg push_valid_o,
  output reg [7:0] push_data_o,
  output reg pop_req_o,
  output reg mask_set_o,
  output reg mask_clear_o,
  output reg wake_o
);

  localparam ST_RESET = 3'd0;
  localparam ST_RUN = 3'd1;
  localparam ST_PUSH = 3'd2;
  localparam ST_VECTOR = 3'd3;
  localparam ST_POP = 3'd4;
  // counts are worked out at full width and cut to their counters
  localparam [31:0] START_FULL = STARTUP_CYCLES;
  localparam [31:0] WDG_FULL = `IRV_WDG_PULSE_CYCLES;
  localparam [31:0] EXT_FULL = `IRV_EXT_RST_MIN_CYCLES;
  localparam [15:0] START_CYC = START_FULL[15:0];
  localparam [7:0] WDG_CYC = WDG_FULL[7:0];
  localparam [8:0] EXT_CYC = EXT_FULL[8:0];

  // ----------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------
  reg [4:0] sync1;
  reg [4:0] sync2;
  reg [1:0] pin_prev;
  reg [1:0] edge_arm;
  // reset levels match idle: oscillator off, no lvd, reset pin high
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 5'h07;
      sync2 <= 5'h07;
      pin_prev <= 2'h3;
      edge_arm <= 2'h0;
    end else begin
      sync1 <= {osc_ready_i, lvd_reset_i, reset_pin_n_i, ext_irq_pin_b_i, ext_irq_pin_a_i};
      sync2 <= sync1;
      pin_prev <= sync2[1:0];
      // edges count only once both stages and pin_prev hold real samples
      if (edge_arm != 2'h3)
        edge_arm <= edge_arm + 2'h1;
    end
  end
  wire pin_a = sync2[0];
  wire pin_b = sync2[1];
  wire rst_pin_n = sync2[2];
  wire lvd_s = sync2[3];
  wire osc_s = sync2[4];
  wire edge_ok = (edge_arm == 2'h3);

  // ----------------------------------------------------------------------
  // reset sequencing
  // ----------------------------------------------------------------------
  reg [7:0] wdg_cnt;
  reg [8:0] ext_cnt;
  reg [15:0] start_cnt;
  wire ext_rst = (ext_cnt >= EXT_CYC);
  wire drive_low = (wdg_cnt != 8'h00) | lvd_s;
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_n_o = ~drive_low;
  wire any_rst = drive_low | wdg_reset_i | illegal_opcode_i | ext_rst;
  always @(posedge clk_i) begin
    if (rst_i) begin
      wdg_cnt <= 8'h00;
      ext_cnt <= 9'h000;
      start_cnt <= 16'h0000;
      cpu_reset_o <= 1'b1;
    end else begin
      if (wdg_reset_i)
        wdg_cnt <= WDG_CYC;
      else if (wdg_cnt != 8'h00)
        wdg_cnt <= wdg_cnt - 8'h01;
      // pin filtered against 1 us minimum
      if (rst_pin_n | drive_low)
        ext_cnt <= 9'h000;
      else if (!ext_rst)
        ext_cnt <= ext_cnt + 9'h001;
      if (any_rst | ~osc_s) begin
        start_cnt <= 16'h0000;
        cpu_reset_o <= 1'b1;
      end else if (start_cnt < START_CYC) begin
        start_cnt <= start_cnt + 16'h0001;
      end else begin
        cpu_reset_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers and edge latches
  // ----------------------------------------------------------------------
  reg [7:0] ext_ctrl;
  reg [7:0] periph_en;
  reg [7:0] periph_lat;
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands at the edge where the master sees ack high
  wire wb_done = wb_cyc_i & wb_stb_i & wb_ack_o;
  wire wb_wr = wb_done & wb_we_i & wb_sel_i[0];
  wire wr_ctrl = wb_wr & (wb_adr_i == `IRV_ADDR_EXT_CTRL);
  // edge found on sampled values; sel high picks rising
  function edge_seen;
    input sel;
    input now;
    input prev;
    begin
      edge_seen = sel ? (now & ~prev) : (~now & prev);
    end
  endfunction
  // hardware set wins over a software clear in the same cycle
  function latch_next;
    input set;
    input cur;
    input clr;
    begin
      latch_next = set | (cur & ~clr);
    end
  endfunction
  wire edge_a = edge_ok & edge_seen(ext_ctrl[`IRV_BIT_EDGE_A], pin_a, pin_prev[0]);
  wire edge_b = edge_ok & edge_seen(ext_ctrl[`IRV_BIT_EDGE_B], pin_b, pin_prev[1]);
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_ctrl <= `IRV_EXT_CTRL_RESET;
      periph_en <= 8'h00;
      periph_lat <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ext_ctrl[`IRV_BIT_EN_A] <= wb_dat_i[`IRV_BIT_EN_A];
        ext_ctrl[`IRV_BIT_EN_B] <= wb_dat_i[`IRV_BIT_EN_B];
        ext_ctrl[`IRV_BIT_EDGE_A] <= wb_dat_i[`IRV_BIT_EDGE_A];
        ext_ctrl[`IRV_BIT_EDGE_B] <= wb_dat_i[`IRV_BIT_EDGE_B];
      end
      ext_ctrl[`IRV_BIT_LAT_A] <= latch_next(edge_a, ext_ctrl[`IRV_BIT_LAT_A],
        wr_ctrl & ~wb_dat_i[`IRV_BIT_LAT_A]);
      ext_ctrl[`IRV_BIT_LAT_B] <= latch_next(edge_b, ext_ctrl[`IRV_BIT_LAT_B],
        wr_ctrl & ~wb_dat_i[`IRV_BIT_LAT_B]);
      ext_ctrl[7:6] <= 2'h0;
      if (wb_wr & (wb_adr_i == `IRV_ADDR_MASK))
        periph_en <= wb_dat_i;
      // clear sequence drops pending request, new flag wins
      periph_lat <= periph_flag_i | (periph_lat & ~periph_clear_i);
    end
  end

  // ----------------------------------------------------------------------
  // priority and vector selection
  // ----------------------------------------------------------------------
  wire ext_a_req = ext_ctrl[`IRV_BIT_LAT_A] & ext_ctrl[`IRV_BIT_EN_A];
  wire ext_b_req = ext_ctrl[`IRV_BIT_LAT_B] & ext_ctrl[`IRV_BIT_EN_B];
  wire [7:0] per_req = periph_lat & periph_en;
  // flag and enable, global mask blocks all but trap
  wire mask_i = cc_i[3];
  wire maskable_any = ~mask_i & ((|per_req) | ext_a_req | ext_b_req);
  reg [15:0] sel_vec;
  always @* begin
    sel_vec = `IRV_VEC_TIM_A;
    if (per_req[0])
      sel_vec = `IRV_VEC_DDC_CI_A;
    else if (per_req[1])
      sel_vec = `IRV_VEC_DDC2B_A;
    else if (per_req[2])
      sel_vec = `IRV_VEC_DDC_CI_B;
    else if (per_req[3])
      sel_vec = `IRV_VEC_DDC2B_B;
    else if (per_req[4])
      sel_vec = `IRV_VEC_IFR;
    else if (ext_a_req)
      sel_vec = `IRV_VEC_EXT_A;
    else if (ext_b_req)
      sel_vec = `IRV_VEC_EXT_B;
    else if (per_req[5])
      sel_vec = `IRV_VEC_I2C;
    else if (per_req[6])
      sel_vec = `IRV_VEC_TIM_B;
  end

  // ----------------------------------------------------------------------
  // service sequencer
  // ----------------------------------------------------------------------
  reg [2:0] state;
  reg [2:0] push_idx;
  reg [15:0] pend_vec;
  reg [7:0] save_pch;
  reg [7:0] save_x;
  reg [7:0] save_a;
  reg [7:0] save_cc;
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_RESET;
      push_idx <= 3'd0;
      pend_vec <= `IRV_VEC_RESET;
      save_pch <= 8'h00;
      save_x <= 8'h00;
      save_a <= 8'h00;
      save_cc <= 8'h00;
      service_o <= 1'b0;
      vector_o <= `IRV_VEC_RESET;
      push_valid_o <= 1'b0;
      push_data_o <= 8'h00;
      pop_req_o <= 1'b0;
      mask_set_o <= 1'b0;
      mask_clear_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      service_o <= 1'b0;
      pop_req_o <= 1'b0;
      mask_set_o <= 1'b0;
      mask_clear_o <= 1'b0;
      wake_o <= wait_mode_i & (trap_exec_i | maskable_any);
      case (state)
        ST_RESET: begin
          vector_o <= `IRV_VEC_RESET;
          if (!cpu_reset_o) begin
            service_o <= 1'b1;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (interrupt_return_instr_exec_i) begin
            // restore from stack, mask from stacked copy
            pop_req_o <= 1'b1;
            state <= ST_POP;
          end else if (trap_exec_i | (instr_end_i & maskable_any)) begin
            // trap ignores mask and instruction end, requests wait for instr_end_i
            pend_vec <= trap_exec_i ? `IRV_VEC_TRAP : sel_vec;
            save_pch <= pc_i[15:8];
            save_x <= x_i;
            save_a <= a_i;
            save_cc <= cc_i;
            push_data_o <= pc_i[7:0];
            push_valid_o <= 1'b1;
            push_idx <= 3'd0;
            state <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          // push pcl, pch, x, a, cc; y not saved
          if (push_ack_i) begin
            push_idx <= push_idx + 3'd1;
            case (push_idx)
              3'd0: push_data_o <= save_pch;
              3'd1: push_data_o <= save_x;
              3'd2: push_data_o <= save_a;
              3'd3: push_data_o <= save_cc;
              default: push_data_o <= 8'h00;
            endcase
            if (push_idx == 3'd4) begin
              push_valid_o <= 1'b0;
              mask_set_o <= 1'b1;
              state <= ST_VECTOR;
            end
          end
        end
        ST_VECTOR: begin
          vector_o <= pend_vec;
          service_o <= 1'b1;
          state <= ST_RUN;
        end
        ST_POP: begin
          mask_set_o <= stacked_cc_i[3];
          mask_clear_o <= ~stacked_cc_i[3];
          state <= ST_RUN;
        end
        default: state <= ST_RESET;
      endcase
      if (cpu_reset_o) begin
        state <= ST_RESET;
        push_valid_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // wishbone read and ack
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 8'h00;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        case (wb_adr_i)
          `IRV_ADDR_EXT_CTRL: wb_dat_o <= {2'h0, ext_ctrl[5:0]};
          `IRV_ADDR_MASK: wb_dat_o <= periph_en;
          `IRV_ADDR_STATUS: wb_dat_o <= periph_lat;
          `IRV_ADDR_VECTOR: wb_dat_o <= vector_o[7:0];
          default: wb_dat_o <= 8'h00;
        endcase
      end
    end
  end

endmodule // irv_top

// [verif/irv_sva.sv]
// assertions on the ports of the interrupt and reset vectoring block
// assumes binding onto irv_top with its startup count handed on
`timescale 1ns/100ps
module irv_sva #(
  parameter STARTUP_CYCLES = 4096
) (
  input wire clk_i,
  input wire rst_i,
  input wire osc_ready_i,
  input wire wdg_reset_i,
  input wire lvd_reset_i,
  input wire illegal_opcode_i,
  input wire trap_exec_i,
  input wire wait_mode_i,
  input wire interrupt_return_instr_exec_i,
  input wire [7:0] stacked_cc_i,
  input wire reset_pin_o,
  input wire reset_pin_oe_n_o,
  input wire cpu_reset_o,
  input wire service_o,
  input wire [15:0] vector_o,
  input wire push_valid_o,
  input wire pop_req_o,
  input wire mask_set_o,
  input wire mask_clear_o,
  input wire wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  integer osc_cnt;
  // cycles with the oscillator running since reset release
  always @(posedge clk_i) begin
    if (rst_i) osc_cnt <= 0;
    else if (osc_ready_i) osc_cnt <= osc_cnt + 1;
  end
  chk_startup_hold: assert property ($fell(cpu_reset_o) |-> osc_cnt >= STARTUP_CYCLES)
    else $error("core reset released before the startup count");
  chk_reset_vector: assert property ($fell(cpu_reset_o) |-> ##[0:8] (service_o && vector_o == 16'hFFFE))
    else $error("no reset vector after core reset");
  chk_wdg_pin: assert property ($rose(wdg_reset_i) |-> ##[1:3] (!reset_pin_oe_n_o) [*8])
    else $error("reset pin not driven after watchdog reset");
  chk_lvd_pin: assert property (lvd_reset_i [*4] |-> !reset_pin_oe_n_o && !reset_pin_o)
    else $error("reset pin not low during low voltage reset");
  chk_illegal_rst: assert property (illegal_opcode_i |-> ##[1:3] cpu_reset_o)
    else $error("illegal opcode gave no reset");
  chk_entry_mask: assert property (service_o && vector_o != 16'hFFFE |-> $past(mask_set_o))
    else $error("service entry without mask set");
  chk_interrupt_return_instr_pop: assert property (interrupt_return_instr_exec_i |=> pop_req_o)
    else $error("return gave no pop request");
  chk_interrupt_return_instr_unmask: assert property (pop_req_o && !stacked_cc_i[3] |-> ##[0:2] mask_clear_o)
    else $error("mask not cleared from stacked copy");
  chk_trap_entry: assert property (trap_exec_i && !push_valid_o |-> ##[1:2] push_valid_o)
    else $error("trap did not start service");
  chk_wait_wake: assert property (wait_mode_i && trap_exec_i |-> ##[1:3] wake_o)
    else $error("request did not wake the core");
endmodule // irv_sva
bind irv_top irv_sva #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_sva (
  .clk_i, .rst_i, .osc_ready_i, .wdg_reset_i, .lvd_reset_i, .illegal_opcode_i, .trap_exec_i,
  .wait_mode_i, .interrupt_return_instr_exec_i, .stacked_cc_i, .reset_pin_o, .reset_pin_oe_n_o, .cpu_reset_o,
  .service_o, .vector_o, .push_valid_o, .pop_req_o, .mask_set_o, .mask_clear_o, .wake_o);

// [verif/irv_core_model.sv]
// cpu core stand-in that accepts the context bytes of a service entry
// assumes push_valid_i holds each byte until it is acked
`timescale 1ns/100ps
module irv_core_model (
  input wire clk_i,
  input wire rst_i,
  input wire push_valid_i,
  input wire [7:0] push_data_i,
  input wire slow_i,
  output reg push_ack_o
);
  logic [7:0] got[$];
  reg gap;
  always @(posedge clk_i) begin
    if (rst_i) begin
      gap <= 1'b0;
      push_ack_o <= 1'b0;
    end else begin
      gap <= ~gap & slow_i;
      if (push_valid_i && !push_ack_o && (!slow_i || gap)) begin
        push_ack_o <= 1'b1;
        got.push_back(push_data_i);
      end else begin
        push_ack_o <= 1'b0;
      end
    end
  end
endmodule // irv_core_model

// [verif/testbench.sv]
// self-checking bench for the interrupt and reset vectoring block
// assumes the core stand-in and the bound checker are compiled with it
`timescale 1ns/100ps
`include "irv_defines.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic osc_ready_i = 1'b0, wdg_reset_i = 1'b0, lvd_reset_i = 1'b0, ext_rst_n = 1'b1;
  logic ext_irq_pin_a_i = 1'b0, ext_irq_pin_b_i = 1'b1, illegal_opcode_i = 1'b0, slow = 1'b0;
  logic trap_exec_i = 1'b0, instr_end_i = 1'b0, wait_mode_i = 1'b0, interrupt_return_instr_exec_i = 1'b0;
  logic [0:0] wb_sel_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00, wb_dat_i = 8'h00, periph_flag_i = 8'h00, periph_clear_i = 8'h00;
  logic [7:0] stacked_cc_i = 8'h00, cc_i = 8'h00, x_i = 8'h00, a_i = 8'h00, g, e;
  logic [15:0] pc_i = 16'h0000;
  wire [7:0] wb_dat_o, push_data_o;
  wire [15:0] vector_o;
  wire wb_ack_o, reset_pin_o, reset_pin_oe_n_o, cpu_reset_o, service_o, push_valid_o;
  wire pop_req_o, mask_set_o, mask_clear_o, wake_o, push_ack_i;
  // open-drain reset pin with pull-up: low when outside or the block pulls it
  wire reset_pin_n_i = ext_rst_n & (reset_pin_oe_n_o | reset_pin_o);
  logic [7:0] exp_q[$];
  logic [31:0] rnd = 32'd82242;
  logic [2:0] seen;
  logic [15:0] vt[3] = '{`IRV_VEC_DDC_CI_A, `IRV_VEC_I2C, `IRV_VEC_TIM_A};
  logic [7:0] bt[3] = '{8'h01, 8'h20, 8'h80};
  int num_errors = 0, checked = 0, ticks = 0, wakes = 0, n, i;
  irv_top #(.STARTUP_CYCLES(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .osc_ready_i(osc_ready_i), .wdg_reset_i(wdg_reset_i), .lvd_reset_i(lvd_reset_i),
    .reset_pin_n_i(reset_pin_n_i), .reset_pin_o(reset_pin_o),
    .reset_pin_oe_n_o(reset_pin_oe_n_o), .cpu_reset_o(cpu_reset_o),
    .ext_irq_pin_a_i(ext_irq_pin_a_i), .ext_irq_pin_b_i(ext_irq_pin_b_i),
    .periph_flag_i(periph_flag_i), .periph_clear_i(periph_clear_i),
    .illegal_opcode_i(illegal_opcode_i), .trap_exec_i(trap_exec_i),
    .instr_end_i(instr_end_i), .wait_mode_i(wait_mode_i), .interrupt_return_instr_exec_i(interrupt_return_instr_exec_i),
    .stacked_cc_i(stacked_cc_i), .cc_i(cc_i), .pc_i(pc_i), .x_i(x_i), .a_i(a_i),
    .push_ack_i(push_ack_i), .service_o(service_o), .vector_o(vector_o),
    .push_valid_o(push_valid_o), .push_data_o(push_data_o), .pop_req_o(pop_req_o),
    .mask_set_o(mask_set_o), .mask_clear_o(mask_clear_o), .wake_o(wake_o));
  irv_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .push_valid_i(push_valid_o),
    .push_data_i(push_data_o), .slow_i(slow), .push_ack_o(push_ack_i));
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ticks++;
    if (wake_o === 1'b1) wakes++;
    if (ticks == 5000) begin
      num_errors++;
      close_out;
    end
  end
  // ----
  // bus, pulse and service helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task close_out;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] ad, dt, ex);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= dt;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    if (!w) `CHK(wb_dat_o, ex)
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task pulse(input int k);
    @(posedge clk_i);
    {illegal_opcode_i, interrupt_return_instr_exec_i, trap_exec_i, instr_end_i, wdg_reset_i} <= 5'h01 << k;
    @(posedge clk_i);
    {illegal_opcode_i, interrupt_return_instr_exec_i, trap_exec_i, instr_end_i, wdg_reset_i} <= 5'h00;
  endtask
  task svc(input logic [15:0] v, input logic ctx);
    int k;
    k = 0;
    while (service_o !== 1'b1 && k < 900) begin
      @(posedge clk_i);
      k++;
    end
    `CHK(vector_o, v)
    if (ctx)
      repeat (5) begin
        g = u_core.got.pop_front();
        e = exp_q.pop_front();
        `CHK(g, e)
      end
  endtask
  task enter(input logic [7:0] cc, input int k, input logic [15:0] v);
    rnd = lfsr(rnd);
    pc_i <= rnd[15:0];
    x_i <= rnd[23:16];
    a_i <= rnd[31:24];
    cc_i <= cc;
    exp_q = '{rnd[7:0], rnd[15:8], rnd[23:16], rnd[31:24], cc};
    pulse(k);
    svc(v, 1'b1);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    osc_ready_i <= 1'b1;
    svc(`IRV_VEC_RESET, 1'b0);
    `CHK(cpu_reset_o, 1'b0)
    wb(0, `IRV_ADDR_EXT_CTRL, 8'h00, `IRV_EXT_CTRL_RESET);
    wb(1, `IRV_ADDR_EXT_CTRL, 8'hFF, 8'h00);
    wb(0, `IRV_ADDR_EXT_CTRL, 8'h00, 8'h2D);
    wb(0, 8'h44, 8'h00, 8'h00);
    wb(1, `IRV_ADDR_EXT_CTRL, 8'h05, 8'h00);
    ext_irq_pin_a_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    wb(0, `IRV_ADDR_EXT_CTRL, 8'h00, 8'h07);
    enter(8'h05, 1, `IRV_VEC_EXT_A);
    wb(1, `IRV_ADDR_EXT_CTRL, 8'h08, 8'h00);
    wb(0, `IRV_ADDR_EXT_CTRL, 8'h00, 8'h08);
    ext_irq_pin_b_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    enter(8'h00, 1, `IRV_VEC_EXT_B);
    wb(1, `IRV_ADDR_EXT_CTRL, 8'h00, 8'h00);
    wb(1, `IRV_ADDR_MASK, 8'hFF, 8'h00);
    periph_flag_i <= 8'hA1;
    cc_i <= 8'h08;
    @(posedge clk_i) periph_flag_i <= 8'h00;
    pulse(1);
    repeat (4) @(posedge clk_i);
    `CHK(push_valid_o, 1'b0)
    wb(0, `IRV_ADDR_STATUS, 8'h00, 8'hA1);
    slow <= 1'b1;
    for (i = 0; i < 3; i++) begin
      enter(8'h00, 1, vt[i]);
      periph_clear_i <= bt[i];
      @(posedge clk_i) periph_clear_i <= 8'h00;
    end
    slow <= 1'b0;
    wb(0, `IRV_ADDR_VECTOR, 8'h00, 8'hE2);
    wb(1, `IRV_ADDR_MASK, 8'h00, 8'h00);
    periph_flag_i <= 8'h10;
    @(posedge clk_i) periph_flag_i <= 8'h00;
    periph_clear_i <= 8'h10;
    @(posedge clk_i) periph_clear_i <= 8'h00;
    wb(1, `IRV_ADDR_MASK, 8'h10, 8'h00);
    wb(0, `IRV_ADDR_STATUS, 8'h00, 8'h00);
    pulse(1);
    repeat (4) @(posedge clk_i);
    `CHK(push_valid_o, 1'b0)
    wait_mode_i <= 1'b1;
    enter(8'h08, 2, `IRV_VEC_TRAP);
    `CHK(wakes, 1)
    wait_mode_i <= 1'b0;
    for (i = 0; i < 2; i++) begin
      stacked_cc_i <= {4'h0, i[0], 3'h0};
      pulse(3);
      seen = 3'b000;
      repeat (4) begin
        @(posedge clk_i);
        seen |= {pop_req_o, mask_set_o, mask_clear_o};
      end
      `CHK(seen, i ? 3'b110 : 3'b101)
    end
    pulse(4);
    svc(`IRV_VEC_RESET, 1'b0);
    pulse(0);
    fork
      begin
        n = 0;
        repeat (200) begin
          @(posedge clk_i);
          n += (reset_pin_oe_n_o === 1'b0);
        end
      end
      svc(`IRV_VEC_RESET, 1'b0);
    join
    `CHK(n, `IRV_WDG_PULSE_CYCLES)
    // outside reset held past the minimum width
    ext_rst_n <= 1'b0;
    repeat (`IRV_EXT_RST_MIN_CYCLES + 8) @(posedge clk_i);
    `CHK(cpu_reset_o, 1'b1)
    ext_rst_n <= 1'b1;
    svc(`IRV_VEC_RESET, 1'b0);
    lvd_reset_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    `CHK(reset_pin_oe_n_o, 1'b0)
    `CHK(reset_pin_o, 1'b0)
    lvd_reset_i <= 1'b0;
    close_out;
  end
endmodule // testbench
